/* shared/tmc_pkg.sv */
// Purpose: Constants for the 16-bit timer/counter block
// Assumes: APB byte addresses, 32-bit data, 8-bit registers in low bits
// Notes:   Each number is named once here
package tmc_pkg;
	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] TMC_OFF_CNT_LO = 8'h00; // count_low_byte
	localparam logic [7:0] TMC_OFF_CNT_HI = 8'h04; // count_high_byte
	localparam logic [7:0] TMC_OFF_IFLG   = 8'h08; // periph_irq_flags
	localparam logic [7:0] TMC_OFF_IEN    = 8'h0c; // periph_irq_enables
	localparam logic [7:0] TMC_OFF_CTL    = 8'h10; // timer_control
	localparam logic [7:0] TMC_OFF_PDIR   = 8'h14; // port_direction_bits
	localparam logic [7:0] TMC_OFF_PIN    = 8'h18; // pin readback
	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int         TMC_CTL_RUN    = 0;     // run_enable
	localparam int         TMC_CTL_CS     = 1;     // clock_source_select
	localparam int         TMC_CTL_NOSYNC = 2;     // no_sync_select
	localparam int         TMC_CTL_OSC    = 3;     // crystal_osc_enable
	localparam int         TMC_CTL_PS     = 4;     // prescale_select low bit
	localparam logic [7:0] TMC_CTL_WMASK  = 8'h3f; // Bits 7..6 unimplemented
	localparam logic [7:0] TMC_CTL_RST    = 8'h00;
	localparam logic [1:0] TMC_PDIR_RST   = 2'h3;  // Pins start as inputs
	localparam int         TMC_IFLG_OVF   = 0;     // overflow_flag
	localparam int         TMC_IEN_OVF    = 0;     // overflow_irq_enable
	localparam logic [3:0] TMC_TRIG_MODE  = 4'hb;  // Special event trigger
	localparam logic [15:0] TMC_CNT_RST   = 16'h0000;
	localparam logic [15:0] TMC_CNT_MAX   = 16'hffff;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int         TMC_SYS_HZ     = 25000000; // sys_clk rate
	localparam int         TMC_INSTR_DIV  = 4;        // Oscillator cycles per instruction
	localparam logic [1:0] TMC_DIV_LAST   = 2'(TMC_INSTR_DIV - 1);
	localparam int         TMC_XTAL_KHZ_MAX = 200;    // Crystal rating
	localparam int         TMC_XTAL_KHZ_NOM = 32;     // Intended crystal
endpackage : tmc_pkg

/* design/tmc_timer.sv */
// Purpose: 16-bit timer/counter with prescaler, crystal pin control, APB
// Assumes: Pins and trigger inputs are synchronous to sys_clk
// Notes:   sys_clk stands for the oscillator; instruction tick is sys_clk/4
//
// Implementation choice: the APB slave port.
`timescale 1ns/10ps

// How it works
// - Count is two readable writable bytes
// - Counts up, wraps all ones to zero
// - Wrap latches the overflow flag
// - Interrupt only while overflow enable set
// - Source select bit picks timer or counter
// - Timer mode counts instruction cycles
// - Counter mode counts external rising edges
// - Counts only while run enable set
// - Either compare unit can reset count
// - Oscillator on forces pins input, read zero
// - Control bits 7 and 6 read zero
// - Bits 5..4 choose the prescale ratio
// - Bit 3 turns crystal oscillator on
// - Bit 2 skips sync in counter mode
// - Unsynced counting runs in sleep, wakes
// - Unsynced count is no compare timebase
// - Byte reads always return valid values
// - Write racing increment wins for the written byte
// - Low power oscillator keeps running asleep
// - Trigger mode 1011 clears the count
// - Trigger reset never sets overflow flag
// - Count write beats a coincident trigger
module tmc_timer (
	input  wire logic        sys_clk,       // Oscillator clock
	input  wire logic        rst_n,         // Synchronous reset, low
	input  wire logic        psel,          // APB select
	input  wire logic        penable,       // APB access phase
	input  wire logic        pwrite,        // APB direction
	input  wire logic [7:0]  paddr,         // APB byte address
	input  wire logic [31:0] pwdata,        // APB write data
	output logic      [31:0] prdata,        // APB read data
	output logic             pready,        // APB ready
	output logic             pslverr,       // APB error
	input  wire logic        sleep_mode,    // Processor asleep
	input  wire logic [1:0]  port_pin_in,   // Pin 0 ext clock, pin 1 crystal in
	input  wire logic [1:0]  port_pin_out,  // Port data to drive
	output logic      [1:0]  port_pin_oe,   // Pin drive enables
	output logic             xtal_amp_en,   // Crystal inverter enable
	input  wire logic [3:0]  cmp1_mode,     // Compare unit 1 mode field
	input  wire logic        cmp1_event,    // Compare unit 1 match pulse
	input  wire logic [3:0]  cmp2_mode,     // Compare unit 2 mode field
	input  wire logic        cmp2_event,    // Compare unit 2 match pulse
	output logic             irq,           // Overflow interrupt request
	output logic             wake,          // Wake request while asleep
	output logic      [15:0] count_value,   // Count for compare units
	output logic             timebase_ok    // Count usable as timebase
);
	import tmc_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [15:0] cnt_reg,  cnt_next;   // Count pair
	logic [2:0]  pre_reg,  pre_next;   // Prescaler
	logic [1:0]  div_reg,  div_next;   // Instruction divider
	logic [7:0]  ctl_reg,  ctl_next;   // timer_control
	logic [1:0]  pdir_reg, pdir_next;  // port_direction_bits
	logic        ovf_reg,  ovf_next;   // overflow_flag
	logic        ien_reg,  ien_next;   // overflow_irq_enable
	logic        s1_reg,   s1_next;    // Sync stage one
	logic        s2_reg,   s2_next;    // Sync stage two
	logic        sp_reg,   sp_next;    // Synced previous
	logic        ar_reg,   ar_next;    // Unsynced sample
	logic        ap_reg,   ap_next;    // Unsynced previous
	logic [31:0] rd_reg,   rd_next;    // Read data
	logic        err_reg,  err_next;   // Read error

	// Decoded control
	logic        run, cs, nosync, osc;
	logic [1:0]  ps;
	logic        src, edge_s, edge_a, div_tick, in_tick, cnt_tick;
	logic        trig, wrap, wr_acc, setup;
	logic        wr_lo, wr_hi, wr_flg, wr_ien, wr_ctl, wr_dir;
	logic        mapped;
	logic [2:0]  pmask;

	// Prescale mask for ratios 1,2,4,8
	function automatic logic [2:0] ps_mask(input logic [1:0] sel);
		case (sel)
			2'd0:    ps_mask = 3'h0;
			2'd1:    ps_mask = 3'h1;
			2'd2:    ps_mask = 3'h3;
			default: ps_mask = 3'h7;
		endcase
	endfunction

	// ----------------------------------------
	// Control decode and bus strobes
	// ----------------------------------------
	always_comb begin
		run    = ctl_reg[TMC_CTL_RUN];
		cs     = ctl_reg[TMC_CTL_CS];
		nosync = ctl_reg[TMC_CTL_NOSYNC];
		osc    = ctl_reg[TMC_CTL_OSC];
		ps     = ctl_reg[TMC_CTL_PS +: 2];
		pmask  = ps_mask(ps);
		setup  = psel & ~penable;
		wr_acc = psel & penable & pwrite;
		wr_lo  = wr_acc & (paddr == TMC_OFF_CNT_LO);
		wr_hi  = wr_acc & (paddr == TMC_OFF_CNT_HI);
		wr_flg = wr_acc & (paddr == TMC_OFF_IFLG);
		wr_ien = wr_acc & (paddr == TMC_OFF_IEN);
		wr_ctl = wr_acc & (paddr == TMC_OFF_CTL);
		wr_dir = wr_acc & (paddr == TMC_OFF_PDIR);
		mapped = (paddr == TMC_OFF_CNT_LO) || (paddr == TMC_OFF_CNT_HI) ||
			(paddr == TMC_OFF_IFLG) || (paddr == TMC_OFF_IEN) ||
			(paddr == TMC_OFF_CTL) || (paddr == TMC_OFF_PDIR) ||
			(paddr == TMC_OFF_PIN);
	end

	// ----------------------------------------
	// Clock sources
	// ----------------------------------------
	// Crystal in pin feeds the counter when the oscillator runs
	always_comb begin
		src      = osc ? port_pin_in[1] : port_pin_in[0];
		s1_next  = src;
		s2_next  = s1_reg;
		sp_next  = s2_reg;
		ar_next  = src;
		ap_next  = ar_reg;
		div_next = div_reg;
		// Phase clocks stop in sleep
		if (!sleep_mode) begin
			div_next = (div_reg == TMC_DIV_LAST) ? 2'h0 : div_reg + 2'h1;
		end else begin
			s2_next = s2_reg;
			sp_next = sp_reg;
		end
		div_tick = (div_reg == TMC_DIV_LAST) & ~sleep_mode;
		edge_s   = s2_reg & ~sp_reg & ~sleep_mode;
		edge_a   = ar_reg & ~ap_reg;
	end

	// Input tick selection by mode
	always_comb begin
		if (!run) begin
			in_tick = 1'b0;
		end else if (!cs) begin
			in_tick = div_tick;
		end else if (nosync) begin
			in_tick = edge_a;
		end else begin
			in_tick = edge_s;
		end
	end

	// ----------------------------------------
	// Prescaler and count
	// ----------------------------------------
	always_comb begin
		trig     = ((cmp1_mode == TMC_TRIG_MODE) & cmp1_event) |
			((cmp2_mode == TMC_TRIG_MODE) & cmp2_event);
		cnt_tick = in_tick & ((pre_reg & pmask) == pmask);
		wrap     = cnt_tick & (cnt_reg == TMC_CNT_MAX);
		pre_next = pre_reg;
		if (in_tick) begin
			pre_next = pre_reg + 3'h1;
		end
		cnt_next = cnt_reg;
		if (cnt_tick) begin
			cnt_next = cnt_reg + 16'h0001;
		end
		if (trig) begin
			cnt_next = TMC_CNT_RST;
		end
		// Write wins over increment and trigger
		if (wr_lo) begin
			cnt_next[7:0] = pwdata[7:0];
		end
		if (wr_hi) begin
			cnt_next[15:8] = pwdata[7:0];
		end
		if (wr_lo | wr_hi) begin
			pre_next = 3'h0;
		end
	end

	// ----------------------------------------
	// Flags, enables, control
	// ----------------------------------------
	always_comb begin
		ovf_next  = ovf_reg;
		ien_next  = ien_reg;
		ctl_next  = ctl_reg;
		pdir_next = pdir_reg;
		if (wr_flg) begin
			ovf_next = pwdata[TMC_IFLG_OVF];
		end
		// Set beats a software clear
		if (wrap & ~trig & ~wr_lo & ~wr_hi) begin
			ovf_next = 1'b1;
		end
		if (wr_ien) begin
			ien_next = pwdata[TMC_IEN_OVF];
		end
		if (wr_ctl) begin
			ctl_next = pwdata[7:0] & TMC_CTL_WMASK;
		end
		if (wr_dir) begin
			pdir_next = pwdata[1:0];
		end
	end

	// ----------------------------------------
	// APB read data, captured in setup
	// ----------------------------------------
	always_comb begin
		rd_next  = rd_reg;
		err_next = err_reg;
		if (setup) begin
			err_next = ~mapped;
			if (paddr == TMC_OFF_CNT_LO) begin
				rd_next = {24'h0, cnt_reg[7:0]};
			end else if (paddr == TMC_OFF_CNT_HI) begin
				rd_next = {24'h0, cnt_reg[15:8]};
			end else if (paddr == TMC_OFF_IFLG) begin
				rd_next = {31'h0, ovf_reg};
			end else if (paddr == TMC_OFF_IEN) begin
				rd_next = {31'h0, ien_reg};
			end else if (paddr == TMC_OFF_CTL) begin
				rd_next = {24'h0, ctl_reg & TMC_CTL_WMASK};
			end else if (paddr == TMC_OFF_PDIR) begin
				rd_next = {30'h0, pdir_reg};
			end else if (paddr == TMC_OFF_PIN) begin
				rd_next = {30'h0, osc ? 2'h0 : port_pin_in};
			end else begin
				rd_next = 32'h0;
			end
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cnt_reg  <= TMC_CNT_RST;
			pre_reg  <= 3'h0;
			div_reg  <= 2'h0;
			ctl_reg  <= TMC_CTL_RST;
			pdir_reg <= TMC_PDIR_RST;
			ovf_reg  <= 1'b0;
			ien_reg  <= 1'b0;
			s1_reg   <= 1'b0;
			s2_reg   <= 1'b0;
			sp_reg   <= 1'b0;
			ar_reg   <= 1'b0;
			ap_reg   <= 1'b0;
			rd_reg   <= 32'h0;
			err_reg  <= 1'b0;
		end else begin
			cnt_reg  <= cnt_next;
			pre_reg  <= pre_next;
			div_reg  <= div_next;
			ctl_reg  <= ctl_next;
			pdir_reg <= pdir_next;
			ovf_reg  <= ovf_next;
			ien_reg  <= ien_next;
			s1_reg   <= s1_next;
			s2_reg   <= s2_next;
			sp_reg   <= sp_next;
			ar_reg   <= ar_next;
			ap_reg   <= ap_next;
			rd_reg   <= rd_next;
			err_reg  <= err_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always_comb begin
		prdata      = rd_reg;
		pready      = 1'b1;
		pslverr     = psel & penable & err_reg;
		// Direction bit 1 means input; oscillator overrides
		port_pin_oe = osc ? 2'h0 : ~pdir_reg;
		xtal_amp_en = osc;
		irq         = ovf_reg & ien_reg;
		wake        = irq & sleep_mode;
		count_value = cnt_reg;
		timebase_ok = ~(cs & nosync);
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_wrap;
		cnt_tick && cnt_reg == 16'hffff && !trig && !wr_lo && !wr_hi;
	endsequence

	property p_ovf_set;
		@(posedge sys_clk) disable iff (!rst_n)
		s_wrap |=> ovf_reg && cnt_reg == 16'h0000;
	endproperty
	a_ovf_set: assert property (p_ovf_set) else $error("wrap lost flag");

	property p_irq;
		@(posedge sys_clk) disable iff (!rst_n)
		irq == (ovf_reg && ien_reg);
	endproperty
	a_irq: assert property (p_irq) else $error("irq gating wrong");

	property p_stop;
		@(posedge sys_clk) disable iff (!rst_n)
		!run && !trig && !wr_lo && !wr_hi |=> $stable(cnt_reg);
	endproperty
	a_stop: assert property (p_stop) else $error("count moved stopped");

	property p_trig;
		@(posedge sys_clk) disable iff (!rst_n)
		trig && !wr_lo && !wr_hi && !wr_flg |=>
			cnt_reg == 16'h0000 && ovf_reg == $past(ovf_reg);
	endproperty
	a_trig: assert property (p_trig) else $error("trigger reset wrong");

	property p_wr_wins;
		@(posedge sys_clk) disable iff (!rst_n)
		trig && wr_lo && !wr_hi |=> cnt_reg[7:0] == $past(pwdata[7:0]);
	endproperty
	a_wr_wins: assert property (p_wr_wins) else $error("write lost");

	property p_timer_rate;
		@(posedge sys_clk) disable iff (!rst_n)
		cnt_tick && !cs && ps == 2'd0 |-> ##1 !(cnt_tick && !cs) [*3];
	endproperty
	a_timer_rate: assert property (p_timer_rate) else $error("timer rate");

	property p_pins;
		@(posedge sys_clk) disable iff (!rst_n)
		osc |-> port_pin_oe == 2'h0;
	endproperty
	a_pins: assert property (p_pins) else $error("pins driven");

	property p_sleep_timer;
		@(posedge sys_clk) disable iff (!rst_n)
		sleep_mode && !cs |-> !cnt_tick;
	endproperty
	a_sleep_timer: assert property (p_sleep_timer) else $error("timer ran asleep");

	property p_ctl_rsvd;
		@(posedge sys_clk) disable iff (!rst_n)
		wr_ctl |=> ctl_reg[7:6] == 2'h0 && ctl_reg[5:0] == $past(pwdata[5:0]);
	endproperty
	a_ctl_rsvd: assert property (p_ctl_rsvd) else $error("control bits");

	property p_base;
		@(posedge sys_clk) disable iff (!rst_n)
		cs && nosync |-> !timebase_ok;
	endproperty
	a_base: assert property (p_base) else $error("timebase flag");

	// Latched flag drops only on a software write
	property p_flag_hold;
		@(posedge sys_clk) disable iff (!rst_n)
		ovf_reg && !wr_flg |=> ovf_reg;
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag not latched");

	// Synced counter mode is frozen with the phase clocks
	property p_sync_sleep;
		@(posedge sys_clk) disable iff (!rst_n)
		sleep_mode && cs && !nosync |-> !cnt_tick;
	endproperty
	a_sync_sleep: assert property (p_sync_sleep) else $error("synced ran asleep");

endmodule // tmc_timer

/* tb/tmc_clk_src.sv */
// Purpose: External count clock source facing the timer block
// Assumes: Bursts are requested on sys_clk rising edges
// Notes:   Pin rests low between bursts, so only burst edges count
`timescale 1ns/10ps
module tmc_clk_src (
	input  wire logic       sys_clk,  // Bench clock
	input  wire logic       start,    // Begin a burst
	input  wire logic [7:0] n_edges,  // Rising edges to send
	input  wire logic [3:0] half,     // Cycles per half period
	output logic            pin,      // Clock pin level
	output logic            busy      // Burst in progress
);
	// ----------------------------------------
	// Burst generator
	// ----------------------------------------
	initial begin
		pin = 1'b0;
		busy = 1'b0;
		forever begin
			@(posedge sys_clk);
			// Start sampled before the bench updates it
			if (start) begin
				busy <= 1'b1;
				repeat (n_edges) begin
					repeat (half) @(posedge sys_clk);
					pin <= 1'b1;
					repeat (half) @(posedge sys_clk);
					pin <= 1'b0;
				end
				busy <= 1'b0;
			end
		end
	end
endmodule // tmc_clk_src

/* tb/tmc_timer_tb.sv */
// Purpose: Self-checking bench for the 16-bit timer/counter
// Assumes: APB answers with pready, read data taken at that edge
// Notes:   Random values from a fixed seed, corner cases by hand
`timescale 1ns/10ps
module tmc_timer_tb;
	import tmc_pkg::*;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, src_n;
	logic [31:0] pwdata, prdata, rd;
	logic        sleep_mode, irq, wake, timebase_ok, xtal_amp_en, err;
	logic [1:0]  port_pin_out, port_pin_oe;
	logic [3:0]  cmp1_mode, cmp2_mode, src_half;
	logic        cmp1_event, cmp2_event, src_start, src_pin, src_busy;
	logic [15:0] count_value, v;
	int          mismatches, compares, seed, cyc, t0, t1, n;

	tmc_timer dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sleep_mode(sleep_mode),
		.port_pin_in({src_pin, src_pin}), .port_pin_out(port_pin_out),
		.port_pin_oe(port_pin_oe), .xtal_amp_en(xtal_amp_en), .cmp1_mode(cmp1_mode),
		.cmp1_event(cmp1_event), .cmp2_mode(cmp2_mode), .cmp2_event(cmp2_event),
		.irq(irq), .wake(wake), .count_value(count_value), .timebase_ok(timebase_ok));
	tmc_clk_src src (.sys_clk(sys_clk), .start(src_start), .n_edges(src_n),
		.half(src_half), .pin(src_pin), .busy(src_busy));

	// ----------------------------------------
	// Clock, cycle count, watchdog
	// ----------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) cyc <= cyc + 1;
	initial begin
		repeat (30000) @(posedge sys_clk);
		mismatches++;
		$display("Watchdog expired");
		print_verdict();
	end

	// ----------------------------------------
	// Tasks and functions
	// ----------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One APB transfer, held until pready is seen high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Cycle at which the count next moves
	task automatic wait_chg(output int t);
		logic [15:0] old;
		old = count_value;
		for (int i = 0; i < 200 && count_value === old; i++) @(negedge sys_clk);
		t = cyc;
	endtask
	function automatic logic [31:0] cv(input logic [1:0] ps, input logic osc,
		input logic nos, input logic cs, input logic run);
		return {26'h0, ps, osc, nos, cs, run};
	endfunction
	// Clock cycles between count steps in timer mode
	function automatic int ticks(input int ps);
		return TMC_INSTR_DIV << ps;
	endfunction
	task automatic fin(input string s);
		$display("Test %s finished", s);
	endtask
	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		seed = 32'he41bf45d;
		{psel, penable, pwrite, paddr, pwdata, sleep_mode} = '0;
		{cmp1_mode, cmp2_mode, cmp1_event, cmp2_event, src_start, src_n} = '0;
		{rst_n, cyc, mismatches, compares} = '0;
		src_half = 4'h2;
		port_pin_out = 2'($random(seed));
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		// Control reset value, unmapped address, control masking, crystal pins
		apb(0, TMC_OFF_CTL, 0);
		chk("control reset", 32'h0, rd);
		apb(0, 8'h1c, 0);
		chk("unmapped error", 32'h1, 32'(err));
		apb(1, TMC_OFF_PDIR, 0);
		apb(1, TMC_OFF_CTL, 32'hff);
		// Start-up delay before relying on the crystal
		repeat (8) @(posedge sys_clk);
		apb(0, TMC_OFF_CTL, 0);
		chk("control bits", 32'h3f, rd);
		@(negedge sys_clk);
		chk("pin enables osc on", 32'h0, 32'(port_pin_oe));
		chk("crystal amp", 32'h1, 32'(xtal_amp_en));
		chk("timebase unsynced", 32'h0, 32'(timebase_ok));
		apb(0, TMC_OFF_PIN, 0);
		chk("pin readback", 32'h0, rd);
		apb(1, TMC_OFF_CTL, 0);
		@(negedge sys_clk);
		chk("pin enables osc off", 32'h3, 32'(port_pin_oe));
		fin("registers");
		// Count bytes written with the counter stopped
		repeat (4) begin
			n = $random(seed);
			apb(1, TMC_OFF_CNT_LO, 32'(n[7:0]));
			apb(1, TMC_OFF_CNT_HI, 32'(n[15:8]));
			apb(0, TMC_OFF_CNT_LO, 0);
			chk("count low", 32'(n[7:0]), rd);
			apb(0, TMC_OFF_CNT_HI, 0);
			chk("count high", 32'(n[15:8]), rd);
		end
		fin("count bytes");
		// Carry-safe byte reads while the timer runs across 00ff
		apb(1, TMC_OFF_CNT_LO, 32'hfe);
		apb(1, TMC_OFF_CNT_HI, 0);
		apb(1, TMC_OFF_CTL, cv(0, 0, 0, 0, 1));
		apb(0, TMC_OFF_CNT_HI, 0);
		v[15:8] = rd[7:0];
		apb(0, TMC_OFF_CNT_LO, 0);
		v[7:0] = rd[7:0];
		apb(0, TMC_OFF_CNT_HI, 0);
		if (rd[7:0] !== v[15:8]) begin
			// High byte moved, low byte must be read again
			v[15:8] = rd[7:0];
			apb(0, TMC_OFF_CNT_LO, 0);
			v[7:0] = rd[7:0];
		end
		chk("carry safe read", 32'h1, 32'(v >= 16'h00fe && v <= 16'h0102));
		// Timer mode spacing for every prescale code, sync bit ignored
		for (int ps = 0; ps < 4; ps++) begin
			apb(1, TMC_OFF_CTL, cv(2'(ps), 0, 1'(ps), 0, 1));
			wait_chg(t0);
			wait_chg(t1);
			chk("tick spacing", 32'(ticks(ps)), 32'(t1 - t0));
		end
		@(posedge sys_clk);
		sleep_mode <= 1'b1;
		@(negedge sys_clk);
		v = count_value;
		repeat (40) @(negedge sys_clk);
		chk("timer asleep", 32'(v), 32'(count_value));
		@(posedge sys_clk);
		sleep_mode <= 1'b0;
		apb(1, TMC_OFF_CTL, cv(0, 0, 0, 0, 0));
		@(negedge sys_clk);
		v = count_value;
		repeat (40) @(negedge sys_clk);
		chk("stopped", 32'(v), 32'(count_value));
		fin("timer mode");
		// Wrap from all ones, flag, enable, wake, clear
		apb(1, TMC_OFF_IFLG, 0);
		apb(1, TMC_OFF_IEN, 0);
		apb(1, TMC_OFF_CNT_LO, 32'hff);
		apb(1, TMC_OFF_CNT_HI, 32'hff);
		apb(1, TMC_OFF_CTL, cv(0, 0, 0, 0, 1));
		wait_chg(t0);
		chk("wrap value", 32'h0, 32'(count_value));
		apb(1, TMC_OFF_CTL, 0);
		apb(0, TMC_OFF_IFLG, 0);
		chk("overflow flag", 32'h1, rd & 32'h1);
		chk("irq masked", 32'h0, 32'(irq));
		apb(1, TMC_OFF_IEN, 1);
		sleep_mode <= 1'b1;
		@(negedge sys_clk);
		chk("irq enabled", 32'h1, 32'(irq));
		chk("wake", 32'h1, 32'(wake));
		@(posedge sys_clk);
		sleep_mode <= 1'b0;
		apb(1, TMC_OFF_IFLG, 0);
		@(negedge sys_clk);
		chk("irq cleared", 32'h0, 32'(irq));
		fin("overflow");
		// External edges, synchronised awake then unsynchronised asleep
		for (int nos = 0; nos < 2; nos++) begin
			apb(1, TMC_OFF_CNT_LO, 0);
			apb(1, TMC_OFF_CNT_HI, 0);
			apb(1, TMC_OFF_CTL, cv(0, 0, 1'(nos), 1, 1));
			n = 1 + ($random(seed) & 15);
			src_n <= 8'(n);
			src_half <= 4'(2 + ($random(seed) & 3));
			sleep_mode <= 1'(nos);
			src_start <= 1'b1;
			@(posedge sys_clk);
			src_start <= 1'b0;
			repeat (2) @(negedge sys_clk);
			for (int i = 0; i < 400 && src_busy === 1'b1; i++) @(negedge sys_clk);
			repeat (8) @(negedge sys_clk);
			chk("edges counted", 32'(n), 32'(count_value));
			chk("timebase", 32'(1 - nos), 32'(timebase_ok));
		end
		@(posedge sys_clk);
		sleep_mode <= 1'b0;
		fin("counter mode");
		// Trigger resets from both compare units, only in trigger mode
		apb(1, TMC_OFF_CTL, 0);
		apb(1, TMC_OFF_IFLG, 0);
		for (int k = 0; k < 4; k++) begin
			// All ones, so a trigger that posed as a wrap would show
			apb(1, TMC_OFF_CNT_LO, 32'hff);
			apb(1, TMC_OFF_CNT_HI, 32'hff);
			cmp1_mode <= (k == 1) ? TMC_TRIG_MODE : 4'h2;
			cmp2_mode <= (k == 3) ? TMC_TRIG_MODE : 4'ha;
			cmp1_event <= (k < 2);
			cmp2_event <= (k >= 2);
			@(posedge sys_clk);
			{cmp1_event, cmp2_event} <= 2'b00;
			repeat (2) @(negedge sys_clk);
			chk("trigger", (k % 2) ? 32'h0 : 32'hffff, 32'(count_value));
		end
		apb(0, TMC_OFF_IFLG, 0);
		chk("flag after trigger", 32'h0, rd & 32'h1);
		// Trigger pulse in the access cycle of a low byte write
		cmp1_mode <= TMC_TRIG_MODE;
		fork
			apb(1, TMC_OFF_CNT_LO, 32'h33);
			begin
				repeat (2) @(posedge sys_clk);
				cmp1_event <= 1'b1;
				@(posedge sys_clk);
				cmp1_event <= 1'b0;
			end
		join
		@(negedge sys_clk);
		chk("write beats trigger", 32'h33, 32'(count_value));
		fin("trigger");
		print_verdict();
	end
endmodule // tmc_timer_tb
